// *** common/usa_pkg.sv ***
// Constants, field layouts and carriers of the UART shadow data access block
package usa_pkg;
   // ****************************************************************
   // Widths and sizes
   // ****************************************************************
   localparam int ADDR_W         = 32;
   localparam int DATA_W         = 32;
   localparam int BYTE_W         = 8;
   localparam int FIFO_DEPTH_DEF = 16;
   localparam int IRQ_W          = 3;

   // ****************************************************************
   // Address map
   // ****************************************************************
   localparam logic [ADDR_W-1:0] SHADOW_RX_TX_DATA_12 = 32'h5000_1160;
   localparam logic [ADDR_W-1:0] SHADOW_RX_TX_DATA_13 = 32'h5000_1164;
   localparam logic [ADDR_W-1:0] SHADOW_STEP          = 32'h0000_0004;
   localparam logic [ADDR_W-1:0] SHADOW_12_INDEX      = 32'h0000_000C;
   localparam logic [ADDR_W-1:0] SHADOW_BASE          = SHADOW_RX_TX_DATA_12 - SHADOW_12_INDEX * SHADOW_STEP;
   localparam logic [ADDR_W-1:0] SHADOW_SPAN          = 32'h0000_0040;
   localparam logic [ADDR_W-1:0] REG_CTRL             = 32'h5000_1100;
   localparam logic [ADDR_W-1:0] REG_LINE_STATUS      = 32'h5000_1104;
   localparam logic [ADDR_W-1:0] REG_IRQ_STATUS       = 32'h5000_1108;
   localparam logic [ADDR_W-1:0] REG_IRQ_MASK         = 32'h5000_110C;

   // ****************************************************************
   // Field positions and reset values
   // ****************************************************************
   localparam int CTRL_FIFO_EN_BIT  = 0;
   localparam int CTRL_IR_MODE_BIT  = 1;
   localparam int LS_DATA_READY_BIT = 0;
   localparam int LS_OVERRUN_BIT    = 1;
   localparam int LS_TX_EMPTY_BIT   = 5;
   localparam int LS_TX_FULL_BIT    = 8;
   localparam int IRQ_OVERRUN_BIT   = 0;
   localparam int IRQ_RX_DATA_BIT   = 1;
   localparam int IRQ_TX_DRAIN_BIT  = 2;
   localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;
   localparam logic [BYTE_W-1:0] BYTE_RESET  = 8'h00;

   // ****************************************************************
   // Carriers
   // ****************************************************************
   typedef struct packed {
      logic fifo_en;
      logic ir_mode;
   } usa_ctrl_t;

   typedef struct packed {
      usa_ctrl_t               ctrl;
      logic                    overrun;
      logic [BYTE_W-1:0]       tx_byte;
      logic                    ser_tx_valid;
      logic                    ir_tx_valid;
      logic [DATA_W-1:0]       rdata;
   } usa_top_state_t;

   // Any of the sixteen aliased shadow words
   function automatic logic usa_is_shadow(input logic [ADDR_W-1:0] addr);
      logic [ADDR_W-1:0] off;
      off = addr - SHADOW_BASE;
      return (addr >= SHADOW_BASE) && (off < SHADOW_SPAN) && (off[1:0] == 2'h0);
   endfunction
endpackage

// *** logic/usa_irq.sv ***
// Sticky event status with mask and one level interrupt
`timescale 1ns/1ps
`default_nettype none
module usa_irq
   import usa_pkg::*;
#(
   parameter int NUM = IRQ_W
) (
   // Clock and reset
   input  wire logic           i_clk,
   input  wire logic           i_rst_n,
   // Events and register writes
   input  wire logic [NUM-1:0] i_event,
   input  wire logic           i_wr_status,
   input  wire logic           i_wr_mask,
   input  wire logic [NUM-1:0] i_wdata,
   // State
   output logic      [NUM-1:0] o_status,
   output logic      [NUM-1:0] o_mask,
   output logic                o_irq
);
   if (NUM < 1 || NUM > DATA_W) begin : g_bad_num
      $error("usa_irq: NUM out of range");
   end

   typedef struct packed {
      logic [NUM-1:0] status;
      logic [NUM-1:0] mask;
      logic           irq;
   } usa_irq_state_t;

   usa_irq_state_t s_reg;
   usa_irq_state_t s_next;

   always_comb begin
      s_next = s_reg;
      // Write one clears; a same-cycle event wins
      if (i_wr_status) begin
         s_next.status = s_reg.status & ~i_wdata;
      end
      s_next.status = s_next.status | i_event;
      if (i_wr_mask) begin
         s_next.mask = i_wdata;
      end
      s_next.irq = |(s_next.status & s_next.mask);
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign o_status = s_reg.status;
   assign o_mask   = s_reg.mask;
   assign o_irq    = s_reg.irq;
endmodule
`default_nettype wire

// *** logic/usa_queue.sv ***
// Byte queue in flip-flops with a single-entry overwrite mode
`timescale 1ns/1ps
`default_nettype none
module usa_queue
   import usa_pkg::*;
#(
   parameter int WIDTH = BYTE_W,
   parameter int DEPTH = FIFO_DEPTH_DEF
) (
   // Clock and reset
   input  wire logic                       i_clk,
   input  wire logic                       i_rst_n,
   // Control
   input  wire logic                       i_flush,
   input  wire logic                       i_single,
   // Queue ports
   input  wire logic                       i_push,
   input  wire logic [WIDTH-1:0]           i_data,
   input  wire logic                       i_pop,
   output logic      [WIDTH-1:0]           o_head,
   output logic      [$clog2(DEPTH+1)-1:0] o_count,
   output logic                            o_full,
   output logic                            o_empty,
   output logic                            o_avail
);
   localparam int PTR_W = $clog2(DEPTH);
   localparam int CNT_W = $clog2(DEPTH+1);

   if (DEPTH < 2 || WIDTH < 1) begin : g_bad_size
      $error("usa_queue: DEPTH must be at least 2 and WIDTH at least 1");
   end

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PTR_W-1:0]            rd_ptr;
      logic [PTR_W-1:0]            wr_ptr;
      logic [CNT_W-1:0]            cnt;
      logic                        empty;
      logic                        avail;
   } usa_queue_state_t;

   usa_queue_state_t s_reg;
   usa_queue_state_t s_next;
   logic             do_pop;
   logic             push_ok;

   function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
      return (p == PTR_W'(DEPTH-1)) ? '0 : p + PTR_W'(1);
   endfunction

   assign o_full  = s_reg.cnt >= (i_single ? CNT_W'(1) : CNT_W'(DEPTH));
   assign o_head  = s_reg.mem[s_reg.rd_ptr];
   assign o_count = s_reg.cnt;
   assign o_empty = s_reg.empty;
   assign o_avail = s_reg.avail;

   always_comb begin
      s_next  = s_reg;
      do_pop  = i_pop && s_reg.avail;
      push_ok = i_push && (!o_full || do_pop);
      if (i_flush) begin
         s_next.rd_ptr = '0;
         s_next.wr_ptr = '0;
         s_next.cnt    = '0;
      end else begin
         // Single mode replaces the lone entry when it is still unread
         if (i_push && o_full && i_single && !do_pop) begin
            s_next.mem[s_reg.rd_ptr] = i_data;
         end else if (push_ok) begin
            s_next.mem[s_reg.wr_ptr] = i_data;
            s_next.wr_ptr            = bump(s_reg.wr_ptr);
         end
         if (do_pop) begin
            s_next.rd_ptr = bump(s_reg.rd_ptr);
         end
         if (push_ok && !do_pop) begin
            s_next.cnt = s_reg.cnt + CNT_W'(1);
         end else if (do_pop && !push_ok) begin
            s_next.cnt = s_reg.cnt - CNT_W'(1);
         end
      end
      s_next.empty = (s_next.cnt == '0);
      s_next.avail = (s_next.cnt != '0);
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_reg       <= '0;
         s_reg.empty <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end
endmodule
`default_nettype wire

// *** logic/usa_top.sv ***
// Shadow receive/transmit data access path of a UART
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module usa_top
   import usa_pkg::*;
#(
   parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
   // Clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_rst_n,
   // Register port
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [DATA_W-1:0] i_wdata,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   output logic      [DATA_W-1:0] o_rdata,
   // Received bytes from the deserialisers
   input  wire logic              i_ser_rx_valid,
   input  wire logic [BYTE_W-1:0] i_ser_rx_byte,
   input  wire logic              i_ir_rx_valid,
   input  wire logic [BYTE_W-1:0] i_ir_rx_byte,
   // Bytes to the serialisers
   output logic                   o_ser_tx_valid,
   output logic                   o_ir_tx_valid,
   output logic      [BYTE_W-1:0] o_tx_byte,
   input  wire logic              i_tx_ready,
   // Flags to the rest of the UART
   output logic                   o_fifo_en,
   output logic                   o_rx_data_ready,
   output logic                   o_tx_holding_empty,
   output logic                   o_overrun,
   output logic                   o_irq
);
   localparam int CNT_W = $clog2(FIFO_DEPTH+1);

   if (FIFO_DEPTH < 2) begin : g_bad_depth
      $error("usa_top: FIFO_DEPTH must be at least 2");
   end

   // ****************************************************************
   // Declarations
   // ****************************************************************
   usa_top_state_t    s_reg;
   usa_top_state_t    s_next;
   logic              rd_shadow;
   logic              wr_shadow;
   logic              flush;
   logic              rx_push;
   logic [BYTE_W-1:0] rx_byte;
   logic              rx_pop;
   logic              rx_overrun;
   logic [BYTE_W-1:0] rx_head;
   logic [CNT_W-1:0]  rx_count;
   logic              rx_full;
   logic              rx_empty;
   logic              tx_push;
   logic              tx_pop;
   logic              tx_out_busy;
   logic [BYTE_W-1:0] tx_head;
   logic [CNT_W-1:0]  tx_count;
   logic              tx_full;
   logic              tx_empty;
   logic [IRQ_W-1:0]  irq_event;
   logic [IRQ_W-1:0]  irq_status;
   logic [IRQ_W-1:0]  irq_mask;

   // ****************************************************************
   // Decode
   // ****************************************************************
   assign rd_shadow = i_rd && usa_is_shadow(i_addr);
   assign wr_shadow = i_wr && usa_is_shadow(i_addr);
   // Changing the FIFO mode empties both paths so no stale bytes cross modes
   assign flush = i_wr && (i_addr == REG_CTRL) && (i_wdata[CTRL_FIFO_EN_BIT] != s_reg.ctrl.fifo_en);

   // ****************************************************************
   // Receive path
   // ****************************************************************
   assign rx_push    = s_reg.ctrl.ir_mode ? i_ir_rx_valid : i_ser_rx_valid;
   assign rx_byte    = s_reg.ctrl.ir_mode ? i_ir_rx_byte : i_ser_rx_byte;
   assign rx_pop     = rd_shadow;
   assign rx_overrun = rx_push && rx_full && !(rx_pop && !rx_empty);

   usa_queue #(
      .WIDTH (BYTE_W),
      .DEPTH (FIFO_DEPTH)
   ) u_rx_queue (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_flush (flush),
      .i_single(!s_reg.ctrl.fifo_en),
      .i_push  (rx_push),
      .i_data  (rx_byte),
      .i_pop   (rx_pop),
      .o_head  (rx_head),
      .o_count (rx_count),
      .o_full  (rx_full),
      .o_empty (rx_empty),
      .o_avail (o_rx_data_ready)
   );

   // ****************************************************************
   // Transmit path
   // ****************************************************************
   assign tx_push     = wr_shadow;
   assign tx_out_busy = (s_reg.ser_tx_valid || s_reg.ir_tx_valid) && !i_tx_ready;
   assign tx_pop      = !tx_out_busy && !tx_empty;

   usa_queue #(
      .WIDTH (BYTE_W),
      .DEPTH (FIFO_DEPTH)
   ) u_tx_queue (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_flush (flush),
      .i_single(!s_reg.ctrl.fifo_en),
      .i_push  (tx_push),
      .i_data  (i_wdata[BYTE_W-1:0]),
      .i_pop   (tx_pop),
      .o_head  (tx_head),
      .o_count (tx_count),
      .o_full  (tx_full),
      .o_empty (o_tx_holding_empty),
      .o_avail ()
   );
   assign tx_empty = o_tx_holding_empty;

   // ****************************************************************
   // Interrupts
   // ****************************************************************
   always_comb begin
      irq_event                   = '0;
      irq_event[IRQ_OVERRUN_BIT]  = rx_overrun;
      irq_event[IRQ_RX_DATA_BIT]  = rx_push && !rx_overrun;
      irq_event[IRQ_TX_DRAIN_BIT] = tx_pop && (tx_count == CNT_W'(1)) && !tx_push && !flush;
   end

   usa_irq #(
      .NUM (IRQ_W)
   ) u_irq (
      .i_clk      (i_clk),
      .i_rst_n    (i_rst_n),
      .i_event    (irq_event),
      .i_wr_status(i_wr && (i_addr == REG_IRQ_STATUS)),
      .i_wr_mask  (i_wr && (i_addr == REG_IRQ_MASK)),
      .i_wdata    (i_wdata[IRQ_W-1:0]),
      .o_status   (irq_status),
      .o_mask     (irq_mask),
      .o_irq      (o_irq)
   );

   // ****************************************************************
   // State update and register reads
   // ****************************************************************
   always_comb begin
      s_next       = s_reg;
      s_next.rdata = RDATA_RESET;
      if (i_wr && (i_addr == REG_CTRL)) begin
         s_next.ctrl.fifo_en = i_wdata[CTRL_FIFO_EN_BIT];
         s_next.ctrl.ir_mode = i_wdata[CTRL_IR_MODE_BIT];
      end
      // Output stage: mode is fixed when the byte is loaded
      if (tx_pop) begin
         s_next.tx_byte      = tx_head;
         s_next.ser_tx_valid = !s_reg.ctrl.ir_mode;
         s_next.ir_tx_valid  = s_reg.ctrl.ir_mode;
      end else if (i_tx_ready) begin
         s_next.ser_tx_valid = 1'b0;
         s_next.ir_tx_valid  = 1'b0;
      end
      // Reading line status clears overrun; a new overrun wins
      if (i_rd && (i_addr == REG_LINE_STATUS)) begin
         s_next.overrun = 1'b0;
      end
      if (rx_overrun) begin
         s_next.overrun = 1'b1;
      end
      if (rd_shadow) begin
         s_next.rdata[BYTE_W-1:0] = rx_empty ? BYTE_RESET : rx_head;
      end else if (i_rd) begin
         case (i_addr)
            REG_CTRL: begin
               s_next.rdata[CTRL_FIFO_EN_BIT] = s_reg.ctrl.fifo_en;
               s_next.rdata[CTRL_IR_MODE_BIT] = s_reg.ctrl.ir_mode;
            end
            REG_LINE_STATUS: begin
               s_next.rdata[LS_DATA_READY_BIT] = !rx_empty;
               s_next.rdata[LS_OVERRUN_BIT]    = s_reg.overrun;
               s_next.rdata[LS_TX_EMPTY_BIT]   = tx_empty;
               s_next.rdata[LS_TX_FULL_BIT]    = tx_full;
            end
            REG_IRQ_STATUS: begin
               s_next.rdata[IRQ_W-1:0] = irq_status;
            end
            REG_IRQ_MASK: begin
               s_next.rdata[IRQ_W-1:0] = irq_mask;
            end
            default: begin
               s_next.rdata = RDATA_RESET;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign o_rdata        = s_reg.rdata;
   assign o_ser_tx_valid = s_reg.ser_tx_valid;
   assign o_ir_tx_valid  = s_reg.ir_tx_valid;
   assign o_tx_byte      = s_reg.tx_byte;
   assign o_fifo_en      = s_reg.ctrl.fifo_en;
   assign o_overrun      = s_reg.overrun;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);

   chk_rx_read_data: assert property (
      rd_shadow && !rx_empty |=> o_rdata[BYTE_W-1:0] == $past(rx_head))
      else $error("shadow read did not return the receive head");

   chk_alias_write: assert property (
      wr_shadow && !tx_full && !flush |=> !tx_empty)
      else $error("write to an aliased shadow word was not queued");

   chk_rx_overwrite: assert property (
      !s_reg.ctrl.fifo_en && !flush && rx_push && rx_full && !rx_pop
      |=> o_overrun && rx_head == $past(rx_byte) && rx_count == CNT_W'(1))
      else $error("unread receive byte not overwritten with overrun");

   chk_rx_pop: assert property (
      s_reg.ctrl.fifo_en && rd_shadow && !rx_empty && !rx_push && !flush
      |=> rx_count == $past(rx_count) - CNT_W'(1))
      else $error("shadow read did not pop the receive FIFO");

   chk_rx_keep: assert property (
      s_reg.ctrl.fifo_en && !flush && rx_push && rx_full && !rx_pop
      |=> o_overrun && rx_head == $past(rx_head) && rx_count == $past(rx_count))
      else $error("full receive FIFO changed on an incoming byte");

   chk_tx_launch: assert property (
      tx_pop |=> (o_ir_tx_valid == $past(s_reg.ctrl.ir_mode)) && (o_ser_tx_valid != o_ir_tx_valid)
                 && o_tx_byte == $past(tx_head))
      else $error("transmit byte not launched on the selected line");

   chk_hold_clear: assert property (
      !s_reg.ctrl.fifo_en && !flush && wr_shadow && tx_empty |=> !o_tx_holding_empty)
      else $error("holding-empty flag not cleared by a write");

   chk_tx_depth: assert property (
      s_reg.ctrl.fifo_en |-> tx_count <= CNT_W'(FIFO_DEPTH) && (tx_full == (tx_count == CNT_W'(FIFO_DEPTH))))
      else $error("transmit FIFO level out of range");

   chk_tx_full_drop: assert property (
      s_reg.ctrl.fifo_en && !flush && wr_shadow && tx_full && !tx_pop |=> tx_count == $past(tx_count))
      else $error("write to a full transmit FIFO was not dropped");

   chk_hi_zero: assert property (
      rd_shadow |=> o_rdata[DATA_W-1:BYTE_W] == '0)
      else $error("upper bits of a shadow read are not zero");

   cov_rx_overrun: cover property (rx_overrun && s_reg.ctrl.fifo_en);
   cov_tx_full:    cover property (tx_full && s_reg.ctrl.fifo_en);
   cov_burst_read: cover property (rd_shadow ##2 rd_shadow ##2 rd_shadow);
   cov_irq:        cover property ($rose(o_irq));
endmodule
`default_nettype wire

// *** testbench/usa_peer.sv ***
// Model of the serial or infrared peer beyond the shadow data path
`timescale 1ns/1ps
`default_nettype none
module usa_peer
   import usa_pkg::*;
(
   // Clock and flow control
   input  wire logic              i_clk,
   input  wire logic              i_stall,
   // Bytes leaving the block
   input  wire logic              i_ser_tx_valid,
   input  wire logic              i_ir_tx_valid,
   input  wire logic [BYTE_W-1:0] i_tx_byte,
   output logic                   o_tx_ready,
   // Bytes entering the block
   output logic                   o_ser_rx_valid,
   output logic                   o_ir_rx_valid,
   output logic      [BYTE_W-1:0] o_rx_byte
);
   // Each taken byte with its infrared flag on top
   logic [BYTE_W:0] got[$];

   assign o_tx_ready = !i_stall;

   initial begin
      o_ser_rx_valid = 1'b0;
      o_ir_rx_valid  = 1'b0;
      o_rx_byte      = 8'h00;
   end

   always @(posedge i_clk) begin
      if ((i_ser_tx_valid || i_ir_tx_valid) && o_tx_ready) begin
         got.push_back({i_ir_tx_valid, i_tx_byte});
      end
   end

   // One byte strobe; the byte lines flip once the strobe is gone
   task automatic send(input logic ir, input logic [BYTE_W-1:0] b);
      @(posedge i_clk);
      o_ser_rx_valid <= !ir;
      o_ir_rx_valid  <= ir;
      o_rx_byte      <= b;
      @(posedge i_clk);
      o_ser_rx_valid <= 1'b0;
      o_ir_rx_valid  <= 1'b0;
      o_rx_byte      <= ~b;
   endtask
endmodule
`default_nettype wire

// *** testbench/usa_top_test.sv ***
// Self-checking bench of the shadow data access block
`timescale 1ns/1ps
`default_nettype none
module usa_top_test
   import usa_pkg::*;
;
   localparam int DEPTH = 4;
   logic              i_clk;
   logic              i_rst_n;
   logic              i_wr;
   logic              i_rd;
   logic              stall;
   logic [ADDR_W-1:0] i_addr;
   logic [DATA_W-1:0] i_wdata;
   logic [DATA_W-1:0] o_rdata;
   logic              ser_rv;
   logic              ir_rv;
   logic              ser_tv;
   logic              ir_tv;
   logic              tx_rdy;
   logic              tx_hold_empty;
   logic              fifo_en;
   logic              rx_rdy;
   logic              ovr;
   logic              irq;
   logic [BYTE_W-1:0] rx_b;
   logic [BYTE_W-1:0] tx_b;
   int                n_mismatch = 0;
   int                comparisons = 0;

   usa_top #(.FIFO_DEPTH(DEPTH)) usa_top_inst (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .o_rdata(o_rdata), .i_ser_rx_valid(ser_rv), .i_ser_rx_byte(rx_b),
      .i_ir_rx_valid(ir_rv), .i_ir_rx_byte(rx_b), .o_ser_tx_valid(ser_tv), .o_ir_tx_valid(ir_tv),
      .o_tx_byte(tx_b), .i_tx_ready(tx_rdy), .o_fifo_en(fifo_en), .o_rx_data_ready(rx_rdy),
      .o_tx_holding_empty(tx_hold_empty), .o_overrun(ovr), .o_irq(irq));

   usa_peer usa_peer_inst (
      .i_clk(i_clk), .i_stall(stall), .i_ser_tx_valid(ser_tv), .i_ir_tx_valid(ir_tv),
      .i_tx_byte(tx_b), .o_tx_ready(tx_rdy), .o_ser_rx_valid(ser_rv), .o_ir_rx_valid(ir_rv),
      .o_rx_byte(rx_b));

   // ****************************************************************
   // Clock, checks and bus tasks
   // ****************************************************************
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   task automatic end_sim();
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge i_clk);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      @(posedge i_clk);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      chk(o_rdata, e);
   endtask

   initial begin
      #200000;
      n_mismatch++;
      end_sim();
   end

   // ****************************************************************
   // Test sequence
   // ****************************************************************
   initial begin
      i_rst_n = 1'b0;
      i_wr    = 1'b0;
      i_rd    = 1'b0;
      i_addr  = 32'h0000_0000;
      i_wdata = 32'h0000_0000;
      stall   = 1'b0;
      repeat (20) @(posedge i_clk);
      i_rst_n <= 1'b1;
      rd(REG_LINE_STATUS, 32'h0000_0020);
      rd(SHADOW_RX_TX_DATA_13, 32'h0000_0000);
      // Unmasked receive event drives the interrupt, write one clears it
      wr(REG_IRQ_MASK, 32'h0000_0002);
      usa_peer_inst.send(1'b0, 8'h77);
      cyc(2);
      chk(DATA_W'(irq), 32'h0000_0001);
      chk(DATA_W'(rx_rdy), 32'h0000_0001);
      rd(REG_IRQ_STATUS, 32'h0000_0002);
      wr(REG_IRQ_STATUS, 32'h0000_0002);
      cyc(1);
      chk(DATA_W'(irq), 32'h0000_0000);
      rd(REG_LINE_STATUS, 32'h0000_0021);
      // Word past the last alias must neither answer nor pop
      rd(SHADOW_BASE + SHADOW_SPAN, 32'h0000_0000);
      rd(SHADOW_BASE + 32'h0000_003C, 32'h0000_0077);
      // Unread byte overwritten without queues
      usa_peer_inst.send(1'b0, 8'h11);
      usa_peer_inst.send(1'b0, 8'h22);
      cyc(1);
      chk(DATA_W'(ovr), 32'h0000_0001);
      rd(REG_LINE_STATUS, 32'h0000_0023);
      rd(SHADOW_RX_TX_DATA_12, 32'h0000_0022);
      rd(REG_LINE_STATUS, 32'h0000_0020);
      // Receive queue fills, drops the extra byte, pops in order
      wr(REG_CTRL, 32'h0000_0001);
      for (int i = 0; i <= DEPTH; i++) begin
         usa_peer_inst.send(1'b0, 8'h30 + 8'(i));
      end
      rd(REG_LINE_STATUS, 32'h0000_0023);
      chk(DATA_W'(fifo_en), 32'h0000_0001);
      for (int i = 0; i < DEPTH; i++) begin
         rd(SHADOW_BASE + 32'(4 * i), 32'h0000_0030 + 32'(i));
      end
      chk(DATA_W'(rx_rdy), 32'h0000_0000);
      rd(REG_LINE_STATUS, 32'h0000_0020);
      // Infrared transmit queue fills while the peer stalls
      wr(REG_CTRL, 32'h0000_0003);
      @(posedge i_clk);
      stall <= 1'b1;
      for (int i = 0; i < DEPTH + 3; i++) begin
         wr(SHADOW_RX_TX_DATA_13, 32'h0000_FF40 + 32'(i));
      end
      rd(REG_LINE_STATUS, 32'h0000_0100);
      @(posedge i_clk);
      stall <= 1'b0;
      cyc(3 * DEPTH + 6);
      // The output stage holds one byte beyond the full queue
      chk(DATA_W'(usa_peer_inst.got.size()), 32'(DEPTH + 1));
      for (int i = 0; i < DEPTH + 1; i++) begin
         chk(DATA_W'(usa_peer_inst.got[i]), 32'h0000_0140 + 32'(i));
      end
      rd(REG_LINE_STATUS, 32'h0000_0020);
      // Infrared mode ignores the serial input
      usa_peer_inst.send(1'b0, 8'h99);
      usa_peer_inst.send(1'b1, 8'h5A);
      rd(SHADOW_RX_TX_DATA_12, 32'h0000_005A);
      rd(REG_LINE_STATUS, 32'h0000_0020);
      // Single holding byte overwritten while the output stage waits
      wr(REG_CTRL, 32'h0000_0000);
      usa_peer_inst.got.delete();
      @(posedge i_clk);
      stall <= 1'b1;
      wr(SHADOW_RX_TX_DATA_12, 32'h0000_0061);
      wr(SHADOW_RX_TX_DATA_12, 32'h0000_0062);
      wr(SHADOW_RX_TX_DATA_13, 32'h0000_0063);
      cyc(1);
      chk(DATA_W'(tx_hold_empty), 32'h0000_0000);
      chk(DATA_W'(fifo_en), 32'h0000_0000);
      @(posedge i_clk);
      stall <= 1'b0;
      cyc(8);
      chk(DATA_W'(usa_peer_inst.got.size()), 32'h0000_0002);
      chk(DATA_W'(usa_peer_inst.got[0]), 32'h0000_0061);
      chk(DATA_W'(usa_peer_inst.got[1]), 32'h0000_0063);
      chk(DATA_W'(tx_hold_empty), 32'h0000_0001);
      end_sim();
   end
endmodule
`default_nettype wire
